// file: logic/mms_pkg.sv
// Constants and types of the measurement mode sequencer.
package mms_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned HOLD_S = 15;
    localparam int unsigned HOLD_CYC = HOLD_S * CLK_HZ;
    localparam int unsigned INIT_MS = 15;
    localparam int unsigned INIT_CYC = INIT_MS * (CLK_HZ / 1000);
    localparam int unsigned DEB_MS = 10;
    localparam int unsigned DEB_CYC = DEB_MS * (CLK_HZ / 1000);
    localparam int unsigned HOLD_W = 28;
    localparam int unsigned INIT_W = 18;
    localparam int unsigned DEB_W = 17;
    localparam logic [12:0] INV_STEPS = 13'h1518;
    localparam int unsigned BTN_GRAV = 0;
    localparam int unsigned BTN_BIAS = 1;
    localparam int unsigned BTN_READ = 2;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] DISP_OFS = 4'h8;
    localparam int unsigned CTRL_ABORT_BIT = 0;
    localparam logic CTRL_ABORT_RST = 1'h0;
    localparam int unsigned ST_MODE_LSB = 0;
    localparam int unsigned ST_HOLD_BIT = 3;
    localparam int unsigned ST_LEVELING_POWER_ON_BIT = 4;
    localparam int unsigned ST_INIT_BIT = 5;
    localparam int unsigned ST_BYP_BIT = 6;
    localparam int unsigned DISP_TEMP_LSB = 0;
    localparam int unsigned DISP_ALARM_LSB = 4;
    typedef enum logic [2:0] {
        MM_STBY, MM_OPER, MM_GRAV, MM_BLEVEL, MM_BEXIT, MM_BMEAS, MM_BRET
    } mms_mode_t;
endpackage : mms_pkg

// file: logic/mms_sequencer.sv
// Mode and power sequencer with display hold and bias inversion steps.
`timescale 1ns/1ps
module mms_sequencer
    import mms_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = HOLD_CYC,
    parameter int unsigned INIT_CYCLES = INIT_CYC,
    parameter int unsigned DEB_CYCLES = DEB_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic mode_on_i,
    input wire logic operate_supply_i,
    input wire logic grav_btn_i,
    input wire logic bias_btn_i,
    input wire logic read_btn_i,
    input wire logic level_done_i,
    input wire logic meas_done_i,
    input wire logic motor_step_i,
    input wire logic [3:0] temp_data_i,
    input wire logic [2:0] oven_alarm_i,
    output logic standby_supply_o,
    output logic operate_en_o,
    output logic leveling_power_on_o,
    output logic neg_logic_relay_n_o,
    output logic motor_supply_relay_n_o,
    output logic logic_supply_o,
    output logic temp_strobe_en_o,
    output logic init_pulse_o,
    output logic display_hold_relay_o,
    output logic display_supply_o,
    output logic grav_selected_o,
    output logic bias_selected_o,
    output logic measurement_selected_o,
    output logic normal_control_o,
    output logic bias_control_o,
    output logic cam_reset_block_o,
    output logic bias_counter_ctrl_o,
    output logic count_down_o,
    output logic level_indicator_en_o,
    output logic inversion_done_o,
    output logic mode_reset_o,
    output logic loop_bypass_o,
    output logic [3:0] temp_digit_o,
    output logic [2:0] alarm_digit_o,
    output logic [1:0] alarm_class_o
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] stb;
        logic [2:0][DEB_W-1:0] db;
        logic on1;
        logic on2;
        logic op1;
        logic op2;
        logic ld1;
        logic ld2;
        logic md1;
        logic md2;
        logic mp1;
        logic mp2;
        logic mp3;
        logic [3:0] t1;
        logic [3:0] t2;
        logic [2:0] a1;
        logic [2:0] a2;
        mms_mode_t st;
        logic [12:0] steps;
        logic [HOLD_W-1:0] hold;
        logic [INIT_W-1:0] init;
        logic vl;
        logic inv_done;
        logic mode_rst;
        logic [3:0] temp;
        logic abort;
        logic [31:0] rdata;
    } mms_state_t;

    localparam mms_state_t RST_VAL = '{st: MM_STBY, abort: CTRL_ABORT_RST, default: '0};

    mms_state_t q_q;
    mms_state_t q_d;
    logic [2:0] press;
    logic allow;
    logic leveling_power_on;
    logic bias_st;
    logic busy;
    logic step;
    logic hold_on;
    logic bypass;
    logic [31:0] stat;
    logic [31:0] disp;

    assign bias_st = q_q.st inside {MM_BLEVEL, MM_BEXIT, MM_BMEAS, MM_BRET};
    assign leveling_power_on = bias_st || (q_q.st == MM_GRAV);
    assign busy = q_q.init != '0;
    assign step = q_q.mp2 && !q_q.mp3;
    assign hold_on = q_q.hold != '0;
    assign allow = q_q.on2 && q_q.op2;
    assign bypass = q_q.stb[BTN_GRAV] && q_q.stb[BTN_READ];

    always_comb begin
        stat = '0;
        stat[ST_MODE_LSB +: 3] = q_q.st;
        stat[ST_HOLD_BIT] = hold_on;
        stat[ST_LEVELING_POWER_ON_BIT] = leveling_power_on;
        stat[ST_INIT_BIT] = busy;
        stat[ST_BYP_BIT] = bypass;
        disp = '0;
        disp[DISP_TEMP_LSB +: 4] = q_q.temp;
        disp[DISP_ALARM_LSB +: 3] = q_q.a2;
    end

    always_comb begin
        q_d = q_q;
        press = '0;
        q_d.s1 = {read_btn_i, bias_btn_i, grav_btn_i};
        q_d.s2 = q_q.s1;
        q_d.on1 = mode_on_i;
        q_d.on2 = q_q.on1;
        q_d.op1 = operate_supply_i;
        q_d.op2 = q_q.op1;
        q_d.ld1 = level_done_i;
        q_d.ld2 = q_q.ld1;
        q_d.md1 = meas_done_i;
        q_d.md2 = q_q.md1;
        q_d.mp1 = motor_step_i;
        q_d.mp2 = q_q.mp1;
        q_d.mp3 = q_q.mp2;
        q_d.t1 = temp_data_i;
        q_d.t2 = q_q.t1;
        q_d.a1 = oven_alarm_i;
        q_d.a2 = q_q.a1;
        q_d.inv_done = 1'b0;
        q_d.mode_rst = 1'b0;
        q_d.abort = 1'b0;
        q_d.rdata = '0;
        q_d.vl = leveling_power_on;

        // A new level must stay stable for the whole window to be taken.
        for (int i = 0; i < 3; i++) begin
            if (q_q.s2[i] == q_q.stb[i]) begin
                q_d.db[i] = '0;
            end else if (q_q.db[i] == DEB_W'(DEB_CYCLES - 1)) begin
                q_d.db[i] = '0;
                q_d.stb[i] = q_q.s2[i];
                press[i] = q_q.s2[i];
            end else begin
                q_d.db[i] = q_q.db[i] + 1'b1;
            end
        end

        if (wr_i && addr_i == CTRL_OFS) begin
            q_d.abort = wdata_i[CTRL_ABORT_BIT];
        end
        if (rd_i) begin
            case (addr_i)
                CTRL_OFS: q_d.rdata = '0;
                STAT_OFS: q_d.rdata = stat;
                DISP_OFS: q_d.rdata = disp;
                default: q_d.rdata = '0;
            endcase
        end

        if (leveling_power_on && !q_q.vl) begin
            q_d.init = INIT_W'(INIT_CYCLES);
        end else if (busy) begin
            q_d.init = q_q.init - 1'b1;
        end

        // The hold restarts on each read press; stored data are left alone.
        if (!q_q.on2) begin
            q_d.hold = '0;
        end else if (press[BTN_READ]) begin
            q_d.hold = HOLD_W'(HOLD_CYCLES);
        end else if (hold_on) begin
            q_d.hold = q_q.hold - 1'b1;
        end

        case (q_q.st)
            MM_STBY: begin
                if (q_q.on2) begin
                    q_d.st = MM_OPER;
                end
            end
            MM_OPER: begin
                if (press[BTN_GRAV] && allow) begin
                    q_d.st = MM_GRAV;
                end else if (press[BTN_BIAS] && allow) begin
                    q_d.st = MM_BLEVEL;
                end
            end
            MM_GRAV: begin
                if (q_q.md2 && !busy) begin
                    q_d.st = MM_OPER;
                    q_d.temp = q_q.t2;
                end
            end
            MM_BLEVEL: begin
                if (q_q.ld2 && !busy) begin
                    q_d.st = MM_BEXIT;
                    q_d.steps = '0;
                end
            end
            MM_BEXIT: begin
                if (step) begin
                    if (q_q.steps == INV_STEPS - 13'h1) begin
                        q_d.steps = '0;
                        q_d.inv_done = 1'b1;
                        q_d.st = MM_BMEAS;
                    end else begin
                        q_d.steps = q_q.steps + 13'h1;
                    end
                end
            end
            MM_BMEAS: begin
                if (q_q.md2 && !busy) begin
                    q_d.st = MM_BRET;
                    q_d.temp = q_q.t2;
                    q_d.steps = '0;
                end
            end
            MM_BRET: begin
                if (step) begin
                    if (q_q.steps == INV_STEPS - 13'h1) begin
                        q_d.steps = '0;
                        q_d.mode_rst = 1'b1;
                        q_d.st = MM_OPER;
                    end else begin
                        q_d.steps = q_q.steps + 13'h1;
                    end
                end
            end
            default: q_d.st = MM_STBY;
        endcase

        if (q_q.abort && leveling_power_on) begin
            q_d.st = MM_OPER;
        end
        if (!q_q.on2) begin
            q_d.st = MM_STBY;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q_q <= RST_VAL;
        end else begin
            q_q <= q_d;
        end
    end

    assign rdata_o = q_q.rdata;
    assign standby_supply_o = 1'b1;
    assign operate_en_o = q_q.st != MM_STBY;
    assign leveling_power_on_o = leveling_power_on;
    assign neg_logic_relay_n_o = !leveling_power_on;
    assign motor_supply_relay_n_o = !leveling_power_on;
    assign logic_supply_o = leveling_power_on;
    assign temp_strobe_en_o = leveling_power_on;
    assign init_pulse_o = busy;
    assign display_hold_relay_o = hold_on;
    assign display_supply_o = hold_on;
    assign grav_selected_o = q_q.st == MM_GRAV;
    assign bias_selected_o = bias_st;
    assign measurement_selected_o = leveling_power_on;
    assign normal_control_o = (q_q.st == MM_GRAV) && !bypass;
    assign bias_control_o = q_q.st inside {MM_BEXIT, MM_BRET};
    assign cam_reset_block_o = bias_st;
    assign bias_counter_ctrl_o = q_q.st inside {MM_BEXIT, MM_BRET};
    assign count_down_o = q_q.st == MM_BRET;
    assign level_indicator_en_o = leveling_power_on && (q_q.st != MM_BRET);
    assign inversion_done_o = q_q.inv_done;
    assign mode_reset_o = q_q.mode_rst;
    assign loop_bypass_o = bypass;
    assign temp_digit_o = q_q.temp;
    assign alarm_digit_o = q_q.a2;
    assign alarm_class_o = q_q.a2[2:1];

    a_standby_power: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        q_q.st == MM_STBY |-> !operate_en_o && !leveling_power_on_o)
        else $error("standby mode powers more than standby domain");

    a_mode_gate: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        q_q.st == MM_OPER && !allow |=> !leveling_power_on_o)
        else $error("mode accepted without operate supply");

    a_grav_select: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        q_q.st == MM_OPER && press[BTN_GRAV] && allow && !q_q.abort
        |=> grav_selected_o && measurement_selected_o && !bias_selected_o)
        else $error("gravity press did not select gravity");

    a_grav_return: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        q_q.st == MM_GRAV && q_q.md2 && !busy && q_q.on2
        |=> q_q.st == MM_OPER && !leveling_power_on_o)
        else $error("gravity cycle end did not return to operate");

    a_hold_start: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        press[BTN_READ] && q_q.on2 |=> display_supply_o [*8])
        else $error("read press did not hold displays");

    a_hold_end: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        q_q.hold == HOLD_W'(1) && !press[BTN_READ] |=> !display_supply_o)
        else $error("display hold outlived its count");

    a_relay_drive: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        neg_logic_relay_n_o == !leveling_power_on_o
        && motor_supply_relay_n_o == !leveling_power_on_o)
        else $error("relay drive is not inverse of leveling power");

    a_init_pulse: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(leveling_power_on_o) |=> init_pulse_o [*8])
        else $error("init pulse missing after relay switch-on");

    a_bias_exit: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        q_q.st == MM_BLEVEL && q_q.ld2 && !busy && q_q.on2 && !q_q.abort
        |=> bias_control_o && cam_reset_block_o)
        else $error("bias leveling did not enter exit submode");

    a_inv_done: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        inversion_done_o |-> $past(q_q.steps) == INV_STEPS - 13'h1
        && $past(q_q.st) == MM_BEXIT)
        else $error("inversion done without full step count");

    a_mode_reset: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        mode_reset_o |-> $past(q_q.st) == MM_BRET && !leveling_power_on_o)
        else $error("mode reset outside return rotation");

    a_count_down: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        count_down_o |-> !level_indicator_en_o)
        else $error("level indicator lit while rotating back");

    a_bypass_block: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        loop_bypass_o |-> !normal_control_o)
        else $error("normal control passed during loop bypass");

    a_bias_select: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        q_q.st == MM_OPER && press[BTN_BIAS] && !press[BTN_GRAV] && allow
        |=> bias_selected_o && measurement_selected_o && !grav_selected_o)
        else $error("bias press did not select bias");

    a_exit_signals: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        q_q.st == MM_BEXIT |-> bias_control_o && cam_reset_block_o && !normal_control_o)
        else $error("exit submode signals wrong");

    a_hold_restart: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        press[BTN_READ] && q_q.on2 && !hold_on |=> q_q.hold == HOLD_W'(HOLD_CYCLES))
        else $error("read press after hold did not restart displays");

    a_temp_latch: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        q_q.st == MM_GRAV && q_q.md2 && !busy |=> temp_digit_o == $past(q_q.t2))
        else $error("temperature digit not latched at cycle end");

    a_stby_return: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !q_q.on2 |=> q_q.st == MM_STBY && !operate_en_o)
        else $error("switch off did not return to standby");
endmodule : mms_sequencer

// file: test/mms_far_side.sv
// Far-side model: leveling completion levels and gimbal motor pulses.
`timescale 1ns/1ps
module mms_far_side (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] dly_i,
    input wire logic lpo_i,
    input wire logic init_i,
    input wire logic bcc_i,
    output logic level_done_o,
    output logic meas_done_o,
    output logic step_o,
    output logic [13:0] steps_o
);
    logic [8:0] cnt_q;
    logic [2:0] ph_q;
    // Settling restarts whenever power, initialisation or the inversion drive breaks it.
    always_ff @(posedge clk_i) begin
        if (rst_i || !lpo_i || init_i || bcc_i) begin
            cnt_q <= 9'h000;
        end else if (cnt_q != 9'h1FF) begin
            cnt_q <= cnt_q + 9'h001;
        end
        if (rst_i || !bcc_i) begin
            ph_q <= 3'h0;
        end else begin
            ph_q <= ph_q + 3'h1;
        end
        if (rst_i) begin
            steps_o <= 14'h0000;
        end else if (bcc_i && ph_q == 3'h0) begin
            steps_o <= steps_o + 14'h0001;
        end
    end
    assign level_done_o = cnt_q >= {1'b0, dly_i};
    assign meas_done_o = cnt_q >= {dly_i, 1'b0};
    assign step_o = bcc_i && !ph_q[2];
endmodule : mms_far_side

// file: test/mms_sequencer_tb_top.sv
// Self-checking bench of the measurement mode sequencer.
`timescale 1ns/1ps
module mms_sequencer_tb_top import mms_pkg::*;;
    localparam int HOLD = 40;
    localparam int INIT = 12;
    localparam int DEB = 4;
    logic clk, rst, wr_s, rd_s, mode_on, op_sup, lvd, msd, mstep;
    logic [3:0] addr, temp, tdig;
    logic [31:0] wdata, rdata, rv;
    logic [2:0] btn, alarm, adig;
    logic [7:0] dly;
    logic [13:0] steps;
    logic [1:0] acls;
    logic sby, open, lpo, rn1, rn2, tstb, init, dsup, gsel, bsel, msel, nctl;
    logic bctl, camb, bcc, cdn, lind, invd, mrst, byp, lsup, dhr;
    int miscompares = 0;
    int n_compared = 0;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    mms_sequencer #(.HOLD_CYCLES(HOLD), .INIT_CYCLES(INIT), .DEB_CYCLES(DEB)) mms_sequencer_inst (
        .core_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
        .rd_i(rd_s), .rdata_o(rdata), .mode_on_i(mode_on), .operate_supply_i(op_sup),
        .grav_btn_i(btn[BTN_GRAV]), .bias_btn_i(btn[BTN_BIAS]), .read_btn_i(btn[BTN_READ]),
        .level_done_i(lvd), .meas_done_i(msd), .motor_step_i(mstep), .temp_data_i(temp),
        .oven_alarm_i(alarm), .standby_supply_o(sby), .operate_en_o(open),
        .leveling_power_on_o(lpo), .neg_logic_relay_n_o(rn1), .motor_supply_relay_n_o(rn2),
        .logic_supply_o(lsup), .temp_strobe_en_o(tstb), .init_pulse_o(init),
        .display_hold_relay_o(dhr), .display_supply_o(dsup), .grav_selected_o(gsel),
        .bias_selected_o(bsel), .measurement_selected_o(msel), .normal_control_o(nctl),
        .bias_control_o(bctl), .cam_reset_block_o(camb), .bias_counter_ctrl_o(bcc),
        .count_down_o(cdn), .level_indicator_en_o(lind), .inversion_done_o(invd),
        .mode_reset_o(mrst), .loop_bypass_o(byp), .temp_digit_o(tdig), .alarm_digit_o(adig),
        .alarm_class_o(acls));
    mms_far_side mms_far_side_inst (
        .clk_i(clk), .rst_i(rst), .dly_i(dly), .lpo_i(lpo), .init_i(init), .bcc_i(bcc),
        .level_done_o(lvd), .meas_done_o(msd), .step_o(mstep), .steps_o(steps));
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        step(1);
        wr_s <= 1'b0;
        step(1);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        addr <= a;
        rd_s <= 1'b1;
        step(1);
        rd_s <= 1'b0;
        rv = rdata;
        step(1);
    endtask : rd
    function automatic logic sel(input int w);
        case (w)
            0: return init;
            1: return dsup;
            2: return invd;
            default: return mrst;
        endcase
    endfunction : sel
    task automatic wait_v(input int w);
        for (int i = 0; i < 70000 && sel(w) !== 1'b1; i++) begin
            step(1);
        end
        if (sel(w) !== 1'b1) begin
            miscompares++;
            $display("MISMATCH wait %0d expected 1 seen %0h", w, sel(w));
            final_report();
        end
    endtask : wait_v
    task automatic span(input int w, input int e, input string n);
        int c;
        c = 0;
        wait_v(w);
        while (sel(w) === 1'b1 && c < 200) begin
            c++;
            step(1);
        end
        chk(n, e, c);
    endtask : span
    task automatic wait_mode(input logic [2:0] m);
        for (int i = 0; i < 1000; i++) begin
            rd(STAT_OFS);
            if (rv[2:0] === m) break;
        end
        chk("mode", m, rv[2:0]);
        if (rv[2:0] !== m) begin
            final_report();
        end
    endtask : wait_mode
    task automatic press(input int b);
        btn[b] <= 1'b1;
        step(DEB + 8);
        btn[b] <= 1'b0;
        step(DEB + 8);
    endtask : press
    task automatic t_reset();
        chk("standby", 1'b1, sby);
        chk("operate", 1'b0, open);
        chk("relay", 1'b1, rn1);
        chk("logic", 1'b0, lsup);
        rd(STAT_OFS);
        chk("status", 32'h0, rv);
        rd(4'hC);
        chk("unmapped", 32'h0, rv);
    endtask : t_reset
    task automatic t_refuse();
        press(BTN_GRAV);
        chk("grav", 1'b0, gsel);
        mode_on <= 1'b1;
        step(4);
        press(BTN_GRAV);
        chk("grav", 1'b0, gsel);
        wait_mode(3'h1);
    endtask : t_refuse
    task automatic t_grav();
        op_sup <= 1'b1;
        step(20);
        temp <= 4'hF;
        btn[BTN_GRAV] <= 1'b1;
        span(0, INIT, "init");
        chk("grav", 1'b1, gsel);
        chk("meas", 1'b1, msel);
        chk("normal", 1'b1, nctl);
        chk("relay1", 1'b0, rn1);
        chk("relay2", 1'b0, rn2);
        chk("strobe", 1'b1, tstb);
        chk("logic", 1'b1, lsup);
        chk("indicator", 1'b1, lind);
        chk("display", 1'b0, dsup);
        btn[BTN_GRAV] <= 1'b0;
        wait_mode(3'h1);
        chk("power", 1'b0, lpo);
        rd(DISP_OFS);
        chk("temp", 4'hF, rv[3:0]);
        chk("tdigit", 4'hF, tdig);
    endtask : t_grav
    task automatic t_read();
        logic [31:0] kept;
        btn[BTN_READ] <= 1'b1;
        span(1, HOLD, "hold");
        btn[BTN_READ] <= 1'b0;
        step(DEB + 8);
        rd(DISP_OFS);
        kept = rv;
        press(BTN_READ);
        chk("display", 1'b1, dsup);
        chk("relay3", 1'b1, dhr);
        rd(DISP_OFS);
        chk("kept", kept, rv);
        for (int a = 0; a < 8; a++) begin
            alarm <= a[2:0];
            step(4);
            chk("alarm", a, adig);
            chk("class", a / 2, acls);
        end
    endtask : t_read
    task automatic t_bias();
        dly <= 8'h0A;
        press(BTN_BIAS);
        chk("bias", 1'b1, bsel);
        chk("meas", 1'b1, msel);
        chk("cam", 1'b1, camb);
        wait_mode(3'h4);
        chk("bctl", 1'b1, bctl);
        chk("counter", 1'b1, bcc);
        wait_v(2);
        chk("steps", INV_STEPS, steps);
        step(1);
        rd(STAT_OFS);
        chk("mode", 3'h5, rv[2:0]);
        wait_mode(3'h6);
        chk("down", 1'b1, cdn);
        chk("indicator", 1'b0, lind);
        wait_v(3);
        chk("steps", {INV_STEPS, 1'b0}, steps);
        wait_mode(3'h1);
    endtask : t_bias
    task automatic t_bypass();
        btn[BTN_GRAV] <= 1'b1;
        btn[BTN_READ] <= 1'b1;
        step(DEB + 8);
        chk("bypass", 1'b1, byp);
        chk("normal", 1'b0, nctl);
        btn[BTN_GRAV] <= 1'b0;
        btn[BTN_READ] <= 1'b0;
        wait_mode(3'h1);
    endtask : t_bypass
    task automatic t_exit();
        dly <= 8'hC8;
        press(BTN_GRAV);
        wait_mode(3'h2);
        wr(CTRL_OFS, 32'h1);
        wait_mode(3'h1);
        mode_on <= 1'b0;
        step(4);
        chk("operate", 1'b0, open);
        chk("standby", 1'b1, sby);
    endtask : t_exit
    initial begin
        rst = 1'b1;
        {wr_s, rd_s, mode_on, op_sup} = 4'h0;
        addr = 4'h0;
        wdata = 32'h0;
        btn = 3'h0;
        temp = 4'h0;
        alarm = 3'h0;
        dly = 8'h64;
        step(2);
        rst <= 1'b0;
        step(1);
        t_reset();
        t_refuse();
        t_grav();
        t_read();
        t_bias();
        t_bypass();
        t_exit();
        final_report();
    end
endmodule : mms_sequencer_tb_top
